/* tb/sdma_engine_assertions.sv */
// port checker for the six-channel transfer engine
// assumes a bind from the bench; sees only the engine's ports
`timescale 1ns/1ps
`include "sdma_regs.svh"
module sdma_chk
    import sdma_pkg::*;
#(
    parameter int NUM_CH = 6
) (
    input wire logic sys_clk, // clock
    input wire logic rst_n, // reset, active low
    input wire logic [7:0] regAddr, // register index
    input wire logic [15:0] regWdata, // register write data
    input wire logic regWr, // write strobe
    input wire logic [`SDMA_NUM_SOURCES-1:0] trigEvents, // trigger pulses
    input sdma_bus_t busReq, // memory-side request
    input wire logic [1:0] frameGrant, // frame grants
    input wire logic [NUM_CH-1:0] chIrq, // channel interrupts
    input wire logic irq // summary interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic armed;
    wire logic mv = busReq.rd || busReq.wr;
    wire logic serial = busReq.addr[15:13] == 3'b110;
    // any register write or event counts, since the checker cannot decode which one triggers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n)
            armed <= 1'b0;
        else if (regWr || |trigEvents)
            armed <= 1'b1;
    end
    a_no_self_start: assert property (busReq.rd |-> armed)
        else $error("bus read before any trigger");
    a_rd_then_wr: assert property (busReq.rd |=> busReq.wr)
        else $error("write does not follow read");
    a_word_gap: assert property (busReq.rd |=> !busReq.rd [*3])
        else $error("words closer than four cycles");
    a_serial_narrow: assert property (mv && serial |-> !busReq.wide)
        else $error("wide access to serial region");
    a_frame1_gate: assert property (mv && busReq.addr[15:12] == 4'h6 |-> frameGrant[0])
        else $error("access to ungranted frame one");
    a_frame2_gate: assert property (mv && serial |-> frameGrant[1])
        else $error("access to ungranted frame two");
    a_irq_pulse: assert property ((chIrq & $past(chIrq)) == '0)
        else $error("channel interrupt longer than one cycle");
    a_irq_hold: assert property ($fell(irq) |-> $past(regWr) || $past(regWr, 2))
        else $error("interrupt dropped without a write");
    a_mask_off: assert property (regWr && regAddr == `SDMA_REG_MASK && regWdata[5:0] == 6'h0
        ##1 !regWr |-> ##1 !irq)
        else $error("interrupt high with all masked");
    cover property (busReq.rd && busReq.wide);
    cover property (busReq.wr && serial);
    cover property ($rose(irq));
endmodule // sdma_chk

/* tb/sdma_mem_model.sv */
// memory-side responder for the transfer engine
// assumes busReq from the engine; answers every read within the cycle in which rd stands
`timescale 1ns/1ps
module sdma_mem_model
    import sdma_pkg::*;
(
    input wire logic sys_clk, // clock
    input sdma_bus_t busReq, // engine request
    output logic [31:0] busRdata, // read data
    output logic [7:0] rdGap // cycles between the last two reads
);
    logic [7:0] tick;
    initial begin
        tick = 8'h0;
        rdGap = 8'h0;
    end
    // data stand only while rd does, else their inverse, so a sample in the wrong cycle shows up
    assign busRdata = busReq.rd ? {~busReq.addr, busReq.addr}
        : {busReq.addr, ~busReq.addr};
    always @(posedge sys_clk) begin
        tick <= busReq.rd ? 8'h1 : tick + 8'h1;
        if (busReq.rd)
            rdGap <= tick;
    end
endmodule // sdma_mem_model

/* tb/tb_six_channel_dma_engine.sv */
// self-checking bench for the six-channel transfer engine
// assumes the package, engine, checker and memory responder compiled first
`timescale 1ns/1ps
`include "sdma_regs.svh"
module tb_six_channel_dma_engine
    import sdma_pkg::*;
;
    logic sys_clk, rst_n, regWr, regRd, irq, ok;
    logic [7:0] regAddr, rdGap;
    logic [15:0] regWdata, regRdata, wAddr;
    logic [`SDMA_NUM_SOURCES-1:0] trigEvents;
    logic [31:0] busRdata, wData;
    logic [1:0] frameGrant;
    logic [5:0] chIrq;
    logic [7:0] seq [4];
    sdma_bus_t busReq;
    int fails, total_checks;
    sdma_engine #(.NUM_CH(6)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .trigEvents(trigEvents), .busReq(busReq), .busRdata(busRdata),
        .frameGrant(frameGrant), .chIrq(chIrq), .irq(irq));
    sdma_mem_model mem (.sys_clk(sys_clk), .busReq(busReq), .busRdata(busRdata),
        .rdGap(rdGap));
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        regRd <= 1'b0;
        #1 chk({16'h0, regRdata}, {16'h0, e});
    endtask
    task automatic chkIrq(input logic e);
        repeat (2) @(posedge sys_clk);
        #1 chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic cfgCh(input int ch, input logic [15:0] s, d, n, st, c);
        logic [7:0] b;
        b = `SDMA_CH_BASE + 8'(ch) * `SDMA_CH_STRIDE;
        wr(b + `SDMA_CH_SRC, s);
        wr(b + `SDMA_CH_DST, d);
        wr(b + `SDMA_CH_COUNT, n);
        wr(b + `SDMA_CH_STEP, st);
        wr(b + `SDMA_CH_CFG, c);
    endtask
    // m zero waits for a bus write, otherwise for a channel interrupt in m
    task automatic waitEv(input int n, input logic must, input logic [5:0] m);
        ok = 1'b0;
        for (int i = 0; i < n && !ok; i++) begin
            @(posedge sys_clk);
            #1;
            if (((m == 6'h0) ? busReq.wr : |(chIrq & m)) === 1'b1) begin
                ok = 1'b1;
                wAddr = busReq.addr;
                wData = busReq.wdata;
            end
        end
        if (must && !ok) begin
            fails++;
            test_done();
        end
    endtask
    task automatic test_done();
        $display("checks=%0d mismatches=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {regWr, regRd, regAddr, regWdata, trigEvents, rst_n} = '0;
        frameGrant = 2'b11;
        fails = 0;
        total_checks = 0;
        repeat (3) @(posedge sys_clk);
        rst_n <= 1'b1;
        wr(8'h08, 16'hFFFF);
        for (int a = 0; a < 3; a++)
            rc(8'(a), 16'h0000);
        rc(`SDMA_REG_BUSY, 16'h0000);
        $display("reset test done");
        wr(`SDMA_REG_MASK, 16'h003F);
        cfgCh(0, 16'h0100, 16'h0200, 16'h0003, 16'h0101, 16'h01F1);
        waitEv(40, 1'b0, 6'h0);
        chk({31'h0, ok}, 32'h0);
        wr(`SDMA_REG_SWTRIG, 16'h0001);
        for (int i = 0; i < 3; i++) begin
            waitEv(20, 1'b1, 6'h0);
            chk({wAddr, wData[15:0]}, {16'h0200 + 16'(i), 16'h0100 + 16'(i)});
        end
        chk({24'h0, rdGap}, 32'h4);
        waitEv(10, 1'b1, 6'h01);
        chkIrq(1'b1);
        rc(`SDMA_REG_STATUS, 16'h0001);
        rc(`SDMA_CH_BASE + `SDMA_CH_COUNT, 16'h0000);
        rc(`SDMA_CH_BASE + `SDMA_CH_CFG, 16'h01F0);
        wr(`SDMA_REG_STATUS, 16'h0001);
        rc(`SDMA_REG_STATUS, 16'h0000);
        chkIrq(1'b0);
        $display("software trigger test done");
        for (int s = 0; s < `SDMA_NUM_SOURCES; s++) begin
            cfgCh(s % 6, 16'h0100, 16'h0300 + 16'(s), 16'h1, 16'h0101, 16'h1 | 16'(s << 4));
            waitEv(20, 1'b0, 6'h0);
            chk({31'h0, ok}, 32'h0);
            @(posedge sys_clk);
            trigEvents <= 11'(1 << s);
            @(posedge sys_clk);
            trigEvents <= '0;
            waitEv(20, 1'b1, 6'h0);
            chk({16'h0, wAddr}, {16'h0, 16'h0300 + 16'(s)});
        end
        $display("event source test done");
        wr(`SDMA_REG_STATUS, 16'h003F);
        wr(`SDMA_REG_MASK, 16'h0000);
        cfgCh(4, 16'h0100, 16'h0200, 16'h0002, 16'h0101, 16'h00F5);
        wr(`SDMA_REG_SWTRIG, 16'h0010);
        #1 chk({26'h0, chIrq}, 32'h10);
        waitEv(20, 1'b1, 6'h0);
        waitEv(20, 1'b1, 6'h0);
        rc(`SDMA_REG_STATUS, 16'h0010);
        chkIrq(1'b0);
        wr(`SDMA_REG_MASK, 16'h0010);
        chkIrq(1'b1);
        wr(`SDMA_REG_STATUS, 16'h0010);
        chkIrq(1'b0);
        $display("interrupt mask test done");
        cfgCh(1, 16'h0100, 16'h0500, 16'h0002, 16'h0101, 16'h00F1);
        cfgCh(2, 16'h0200, 16'h0600, 16'h0002, 16'h0101, 16'h00F1);
        wr(`SDMA_REG_SWTRIG, 16'h0006);
        for (int i = 0; i < 4; i++) begin
            waitEv(20, 1'b1, 6'h0);
            seq[i] = wAddr[15:8];
        end
        chk({seq[0], seq[1], seq[2], seq[3]}, 32'h05060506);
        wr(`SDMA_REG_CTRL, 16'h0001);
        cfgCh(0, 16'h0100, 16'h0700, 16'h0002, 16'hFF02, 16'h00F1);
        cfgCh(2, 16'h0200, 16'h0600, 16'h0002, 16'h0101, 16'h00F1);
        wr(`SDMA_REG_SWTRIG, 16'h0005);
        for (int i = 0; i < 4; i++) begin
            waitEv(20, 1'b1, 6'h0);
            seq[i] = wAddr[7:0];
            chk({16'h0, wData[15:0]}, {16'h0, (i < 2) ? 16'h0100 + 16'(2 * i)
                : 16'h0200 + 16'(i - 2)});
        end
        chk({seq[0], seq[1], seq[2], seq[3]}, 32'h00FF0001);
        $display("priority test done");
        cfgCh(3, 16'h6000, 16'h0410, 16'h0001, 16'h0101, 16'h00F3);
        wr(`SDMA_REG_SWTRIG, 16'h0008);
        waitEv(20, 1'b1, 6'h0);
        chk(wData, 32'h9FFF6000);
        cfgCh(3, 16'h0400, 16'hC000, 16'h0001, 16'h0101, 16'h00F3);
        wr(`SDMA_REG_SWTRIG, 16'h0008);
        waitEv(20, 1'b1, 6'h0);
        chk({wAddr, wData[15:0]}, 32'hC0000400);
        @(posedge sys_clk);
        frameGrant <= 2'b01;
        cfgCh(3, 16'h0400, 16'hD000, 16'h0001, 16'h0101, 16'h00F3);
        wr(`SDMA_REG_SWTRIG, 16'h0008);
        waitEv(30, 1'b0, 6'h0);
        chk({31'h0, ok}, 32'h0);
        rc(`SDMA_REG_BUSY, 16'h0800);
        // unused source codes must ignore every event line
        cfgCh(5, 16'h0100, 16'h0800, 16'h0001, 16'h0101, 16'h00B1);
        @(posedge sys_clk);
        trigEvents <= '1;
        @(posedge sys_clk);
        trigEvents <= '0;
        waitEv(20, 1'b0, 6'h0);
        chk({31'h0, ok}, 32'h0);
        $display("width and frame test done");
        test_done();
    end
endmodule // tb_six_channel_dma_engine
bind sdma_engine sdma_chk #(.NUM_CH(NUM_CH)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .trigEvents(trigEvents),
    .busReq(busReq), .frameGrant(frameGrant), .chIrq(chIrq), .irq(irq));

/* verilog/sdma_channel.sv */
// one transfer channel: configuration, trigger select and address sequencing
// assumes the engine grants it at most one word per grant pulse
`timescale 1ns/1ps
`include "sdma_regs.svh"
module sdma_channel
    import sdma_pkg::*;
(
    input wire logic sys_clk, // system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [2:0] regSel, // channel register select
    input wire logic regWr, // write strobe for this channel
    input wire logic [15:0] regWdata, // write data
    input wire logic [`SDMA_NUM_SOURCES-1:0] events, // peripheral trigger events
    input wire logic softTrig, // software trigger pulse
    input wire logic wordDone, // granted word finished
    output sdma_ch_t chState, // channel state
    output logic startPulse, // transfer began
    output logic donePulse // transfer completed
);
    sdma_ch_t st, next_st;
    logic [3:0] sel;
    logic trig;
    logic [15:0] stepSrc, stepDst;

    function automatic logic [15:0] sext8(input logic [7:0] v);
        sext8 = {{8{v[7]}}, v};
    endfunction

    always_comb begin
        next_st = st;
        startPulse = 1'b0;
        donePulse = 1'b0;
        sel = st.cfg[`SDMA_CFG_TRIG_LSB +: `SDMA_CFG_TRIG_W];
        // external events or the software trigger, no timer inside
        if (sel == `SDMA_TRIG_SOFT) begin
            trig = softTrig;
        end else if (sel < 4'(`SDMA_NUM_SOURCES)) begin
            trig = events[sel];
        end else begin
            trig = 1'b0;
        end
        stepSrc = sext8(st.srcStep);
        stepDst = sext8(st.dstStep);
        if (regWr) begin
            if (regSel == `SDMA_CH_SRC) begin
                next_st.src = regWdata;
            end else if (regSel == `SDMA_CH_DST) begin
                next_st.dst = regWdata;
            end else if (regSel == `SDMA_CH_COUNT) begin
                next_st.count = regWdata;
            end else if (regSel == `SDMA_CH_CFG) begin
                next_st.cfg = regWdata;
            end else if (regSel == `SDMA_CH_ALTSRC) begin
                next_st.altSrc = regWdata;
            end else if (regSel == `SDMA_CH_ALTDST) begin
                next_st.altDst = regWdata;
            end else if (regSel == `SDMA_CH_STEP) begin
                next_st.srcStep = regWdata[7:0];
                next_st.dstStep = regWdata[15:8];
            end
        end
        if (trig && st.cfg[`SDMA_CFG_ENABLE] && !st.active && st.count != 16'h0000) begin
            next_st.active = 1'b1;
            next_st.left = st.count;
            next_st.curSrc = st.useAlt ? st.altSrc : st.src;
            next_st.curDst = st.useAlt ? st.altDst : st.dst;
            startPulse = 1'b1;
        end
        next_st.pending = next_st.active;
        if (wordDone && st.active) begin
            next_st.curSrc = st.curSrc + stepSrc;
            next_st.curDst = st.curDst + stepDst;
            next_st.left = st.left - 16'h0001;
            if (st.left == 16'h0001) begin
                next_st.active = 1'b0;
                next_st.pending = 1'b0;
                donePulse = 1'b1;
                if (st.cfg[`SDMA_CFG_PINGPONG]) begin
                    next_st.useAlt = !st.useAlt;
                end
                if (st.cfg[`SDMA_CFG_ONESHOT]) begin
                    next_st.cfg[`SDMA_CFG_ENABLE] = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign chState = st;
endmodule // sdma_channel

/* verilog/sdma_engine.sv */
// six-channel transfer engine: register port, arbitration, word mover, interrupts
// assumes a bus that answers a read within the cycle in which rd stands and never stalls
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`include "sdma_regs.svh"
module sdma_engine
    import sdma_pkg::*;
#(
    parameter int NUM_CH = `SDMA_NUM_CH
) (
    input wire logic sys_clk, // 25 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic [7:0] regAddr, // register word index
    input wire logic [15:0] regWdata, // register write data
    input wire logic regWr, // register write strobe
    input wire logic regRd, // register read strobe
    output logic [15:0] regRdata, // read data, cycle after regRd
    input wire logic [`SDMA_NUM_SOURCES-1:0] trigEvents, // peripheral trigger pulses
    output sdma_bus_t busReq, // memory-side request
    input wire logic [31:0] busRdata, // read data, sampled in the cycle in which rd stands
    input wire logic [1:0] frameGrant, // peripheral frame 1 and 2 granted
    output logic [NUM_CH-1:0] chIrq, // per-channel interrupt lines
    output logic irq // masked summary interrupt
);
    typedef struct packed {
        sdma_phase_t phase;
        logic [2:0] cur;
        logic [2:0] rrLast;
        logic [1:0] gap;
        logic [31:0] data;
        logic [15:0] ctrl;
        logic [NUM_CH-1:0] status;
        logic [NUM_CH-1:0] mask;
        logic [NUM_CH-1:0] chIrqLine;
        logic [15:0] rdata;
        logic [15:0] fault;
        sdma_bus_t bus;
    } sdma_top_t;

    sdma_top_t st, next_st;
    sdma_ch_t chs [NUM_CH];
    logic [NUM_CH-1:0] startP, doneP, chWr, softTrig, wordDone;
    logic [2:0] regSel;
    logic [15:0] evMask;

    // decode upper nibble: regions 0xC/0xD are serial ports in this map
    function automatic logic isSerial(input logic [15:0] a);
        isSerial = (a[15:12] == `SDMA_SERIAL_HI) || (a[15:12] == 4'hD);
    endfunction

    // frame 1 at 0x6xxx, frame 2 at 0xCxxx/0xDxxx; other regions always open
    function automatic logic frameOk(input logic [15:0] a, input logic [1:0] g);
        if (a[15:12] == 4'h6) begin
            frameOk = g[0];
        end else if (isSerial(a)) begin
            frameOk = g[1];
        end else begin
            frameOk = 1'b1;
        end
    endfunction

    // reachable-only modules have no event input here
    assign evMask = 16'(trigEvents);

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
            assign chWr[gi] = regWr && (regAddr[7:3] == 5'(8'(`SDMA_CH_BASE + gi *
                `SDMA_CH_STRIDE) >> 3));
            assign softTrig[gi] = regWr && (regAddr == `SDMA_REG_SWTRIG) && regWdata[gi];
            assign wordDone[gi] = (st.phase == SDMA_WRITE) && (st.cur == 3'(gi));
            sdma_channel u_ch (
                .sys_clk(sys_clk),
                .rst_n(rst_n),
                .regSel(regSel),
                .regWr(chWr[gi]),
                .regWdata(regWdata),
                .events(evMask[`SDMA_NUM_SOURCES-1:0]),
                .softTrig(softTrig[gi]),
                .wordDone(wordDone[gi]),
                .chState(chs[gi]),
                .startPulse(startP[gi]),
                .donePulse(doneP[gi])
            );
        end
    endgenerate

    assign regSel = regAddr[2:0];

    always_comb begin
        logic found;
        logic [2:0] pick;
        logic [2:0] idx;
        logic wide;
        found = 1'b0;
        pick = 3'h0;
        idx = 3'h0;
        wide = 1'b0;
        next_st = st;
        next_st.bus.rd = 1'b0;
        next_st.bus.wr = 1'b0;
        for (int i = 0; i < NUM_CH; i++) begin
            next_st.chIrqLine[i] = chs[i].cfg[`SDMA_CFG_IRQ_AT_START] ? startP[i] : doneP[i];
        end
        // sticky status: set wins over write-one-to-clear
        if (regWr && regAddr == `SDMA_REG_STATUS) begin
            next_st.status = st.status & ~regWdata[NUM_CH-1:0];
        end
        next_st.status = next_st.status | next_st.chIrqLine;
        if (regWr && regAddr == `SDMA_REG_MASK) begin
            next_st.mask = regWdata[NUM_CH-1:0];
        end
        if (regWr && regAddr == `SDMA_REG_CTRL) begin
            next_st.ctrl = regWdata;
        end
        next_st.rdata = 16'h0000;
        if (regRd) begin
            if (regAddr == `SDMA_REG_CTRL) begin
                next_st.rdata = st.ctrl;
            end else if (regAddr == `SDMA_REG_STATUS) begin
                next_st.rdata = 16'(st.status);
            end else if (regAddr == `SDMA_REG_MASK) begin
                next_st.rdata = 16'(st.mask);
            end else if (regAddr == `SDMA_REG_BUSY) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    next_st.rdata[i] = chs[i].active;
                end
                next_st.rdata[15:8] = st.fault[7:0];
            end else if (regAddr >= `SDMA_CH_BASE) begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (regAddr[7:3] == 5'(8'(`SDMA_CH_BASE + i * `SDMA_CH_STRIDE) >> 3)) begin
                        if (regSel == `SDMA_CH_SRC) begin
                            next_st.rdata = chs[i].src;
                        end else if (regSel == `SDMA_CH_DST) begin
                            next_st.rdata = chs[i].dst;
                        end else if (regSel == `SDMA_CH_COUNT) begin
                            next_st.rdata = chs[i].left;
                        end else if (regSel == `SDMA_CH_CFG) begin
                            next_st.rdata = chs[i].cfg;
                        end else if (regSel == `SDMA_CH_ALTSRC) begin
                            next_st.rdata = chs[i].altSrc;
                        end else if (regSel == `SDMA_CH_ALTDST) begin
                            next_st.rdata = chs[i].altDst;
                        end else if (regSel == `SDMA_CH_STEP) begin
                            next_st.rdata = {chs[i].dstStep, chs[i].srcStep};
                        end
                    end
                end
            end
        end
        // channel one may pre-empt the rotation
        if (st.ctrl[`SDMA_CTRL_CH1_HIGH] && chs[0].pending) begin
            found = 1'b1;
            pick = 3'h0;
        end
        for (int k = 1; k <= NUM_CH; k++) begin
            idx = 3'((int'(st.rrLast) + k) % NUM_CH);
            if (!found && chs[idx].pending) begin
                found = 1'b1;
                pick = idx;
            end
        end
        case (st.phase)
            SDMA_IDLE: begin
                if (found) begin
                    wide = chs[pick].cfg[`SDMA_CFG_WIDE];
                    if (isSerial(chs[pick].curSrc) || isSerial(chs[pick].curDst)) begin
                        wide = 1'b0;
                    end
                    next_st.cur = pick;
                    next_st.bus.addr = chs[pick].curSrc;
                    next_st.bus.wide = wide;
                    // source and destination regions must each be ungated or in a granted frame
                    if (frameOk(chs[pick].curSrc, frameGrant) &&
                        frameOk(chs[pick].curDst, frameGrant)) begin
                        next_st.bus.rd = 1'b1;
                    end else begin
                        next_st.fault = st.fault | 16'(1 << pick);
                    end
                    next_st.phase = SDMA_READ;
                end
            end
            SDMA_READ: begin
                next_st.data = st.bus.wide ? busRdata : {16'h0000, busRdata[15:0]};
                next_st.bus.addr = chs[st.cur].curDst;
                next_st.bus.wdata = next_st.data;
                next_st.bus.wr = st.bus.rd;
                next_st.phase = SDMA_WRITE;
            end
            SDMA_WRITE: begin
                next_st.rrLast = st.cur;
                next_st.gap = 2'h0;
                next_st.phase = SDMA_GAP;
            end
            SDMA_GAP: begin
                next_st.gap = st.gap + 2'h1;
                if (st.gap == 2'(`SDMA_WORD_CYCLES - 4)) begin
                    next_st.phase = SDMA_IDLE;
                end
            end
            default: begin
                next_st.phase = SDMA_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign busReq = st.bus;
    assign regRdata = st.rdata;
    assign chIrq = st.chIrqLine;
    assign irq = |(st.status & st.mask);
endmodule // sdma_engine

/* verilog/sdma_pkg.sv */
// types shared by the engine and its channel slice
package sdma_pkg;
    typedef enum logic [1:0] {
        SDMA_IDLE = 2'b00,
        SDMA_READ = 2'b01,
        SDMA_WRITE = 2'b10,
        SDMA_GAP = 2'b11
    } sdma_phase_t;

    typedef struct packed {
        logic [15:0] src;
        logic [15:0] dst;
        logic [15:0] altSrc;
        logic [15:0] altDst;
        logic [15:0] count;
        logic [15:0] cfg;
        logic [7:0] srcStep;
        logic [7:0] dstStep;
        logic [15:0] left;
        logic [15:0] curSrc;
        logic [15:0] curDst;
        logic useAlt;
        logic pending;
        logic active;
    } sdma_ch_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wdata;
        logic rd;
        logic wr;
        logic wide;
    } sdma_bus_t;
endpackage

/* verilog/sdma_regs.svh */
// register map, field positions and timing counts of the six-channel transfer engine
// assumes a 16-bit register port addressed by word index
`ifndef SDMA_REGS_SVH
`define SDMA_REGS_SVH
`define SDMA_NUM_CH 6
`define SDMA_REG_CTRL 8'h00
`define SDMA_REG_STATUS 8'h01
`define SDMA_REG_MASK 8'h02
`define SDMA_REG_SWTRIG 8'h03
`define SDMA_REG_BUSY 8'h04
`define SDMA_CH_BASE 8'h10
`define SDMA_CH_STRIDE 8'h08
`define SDMA_CH_SRC 3'h0
`define SDMA_CH_DST 3'h1
`define SDMA_CH_COUNT 3'h2
`define SDMA_CH_CFG 3'h3
`define SDMA_CH_ALTSRC 3'h4
`define SDMA_CH_ALTDST 3'h5
`define SDMA_CH_STEP 3'h6
`define SDMA_CFG_ENABLE 0
`define SDMA_CFG_WIDE 1
`define SDMA_CFG_IRQ_AT_START 2
`define SDMA_CFG_PINGPONG 3
`define SDMA_CFG_TRIG_LSB 4
`define SDMA_CFG_TRIG_W 4
`define SDMA_CFG_ONESHOT 8
`define SDMA_CTRL_CH1_HIGH 0
`define SDMA_TRIG_SOFT 4'hF
`define SDMA_NUM_SOURCES 11
`define SDMA_WORD_CYCLES 4
`define SDMA_SERIAL_HI 4'hC
`endif
